//--- core/mon_acq_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module mon_acq_ctrl #(
   parameter int unsigned CONV_CYCLES = mon_pkg::CONV_CYCLES_DEFAULT
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Serial bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Address pins and supply monitor
   input wire logic addr_select_bit0_i,
   input wire logic addr_select_bit1_i,
   input wire logic addr_select_bit2_i,
   input wire logic undervoltage_lockout_i,
   // Converter
   output logic adc_start_o,
   output logic [2:0] adc_kind_o,
   output logic [3:0] adc_chan_o,
   output logic [1:0] adc_step_o,
   output logic adc_kelvin_o,
   input wire logic adc_done_i,
   input wire logic [mon_pkg::RESULT_W-1:0] adc_result_i,
   // Remote diode current sources and status
   output logic [mon_pkg::NUM_PAIRS-1:0] isrc_en_o,
   output logic seq_busy_o
);
   import mon_pkg::*;

   localparam int PIN_W = 6;

   logic [PIN_W-1:0] pin_meta_q;
   logic [PIN_W-1:0] pin_sync_q;
   logic [1:0] bus_dly_q;

   // All pins pass two flops; 8 ns sampling is far above 400 kbit/s.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pin_meta_q <= PIN_IDLE;
         pin_sync_q <= PIN_IDLE;
         bus_dly_q <= 2'b11;
      end
      else
      begin
         pin_meta_q <= {undervoltage_lockout_i, addr_select_bit2_i,
                        addr_select_bit1_i, addr_select_bit0_i, sda_i, scl_i};
         pin_sync_q <= pin_meta_q;
         bus_dly_q <= pin_sync_q[1:0];
      end
   end

   wire scl_s = pin_sync_q[0];
   wire sda_s = pin_sync_q[1];
   wire [2:0] addr_pins = pin_sync_q[4:2];
   wire undervoltage_lockout_s = pin_sync_q[5];
   wire scl_rise = scl_s & ~bus_dly_q[0];
   wire scl_fall = ~scl_s & bus_dly_q[0];
   wire start_cond = scl_s & bus_dly_q[0] & ~sda_s & bus_dly_q[1];
   wire stop_cond = scl_s & bus_dly_q[0] & sda_s & ~bus_dly_q[1];

   i2c_state_e ist_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] sr_q;
   logic [7:0] tx_q;
   logic [7:0] ptr_q;
   logic ack_slot_q;
   logic rw_q;
   logic nack_q;
   logic sda_oe_q;
   logic sda_o_q;
   logic [7:0] en_q;
   logic [7:0] pair_q;
   logic [7:0] cfg_q;
   logic [7:0] hi_q [NUM_CH];
   logic [7:0] lo_q [NUM_CH];
   logic [NUM_CH-1:0] valid_vec;
   logic seq_busy_q;

   wire active = (ist_q != I_IDLE);
   wire byte_done = active & scl_fall & (bit_cnt_q == 4'd8) & ~ack_slot_q;
   wire ack_end = active & scl_fall & ack_slot_q;
   wire addr_hit = (sr_q[7:1] == {ADDR_PREFIX, addr_pins});
   wire do_ack = ((ist_q == I_ADDR) & addr_hit) | (ist_q == I_PTR) |
                 (ist_q == I_WDATA);
   wire reg_wr = byte_done & (ist_q == I_WDATA);
   wire rd_load = ack_end & (((ist_q == I_ADDR) & rw_q) |
                             ((ist_q == I_RDATA) & ~nack_q));
   wire read_busy = (ist_q == I_RDATA);
   wire trig_pulse = reg_wr & (ptr_q == REG_TRIGGER);

   // Register read decode.
   wire [7:0] data_off = ptr_q - REG_DATA_BASE;
   wire [3:0] rd_ch = data_off[4:1];
   wire rd_is_data = (ptr_q >= REG_DATA_BASE) & (ptr_q <= REG_DATA_LAST);
   wire [7:0] status_hi = {seq_busy_q, 5'h00, valid_vec[9:8]};
   wire [7:0] rd_data =
      rd_is_data ? (data_off[0] ? lo_q[rd_ch] : hi_q[rd_ch]) :
      (ptr_q == REG_STATUS_LO) ? valid_vec[7:0] :
      (ptr_q == REG_STATUS_HI) ? status_hi :
      (ptr_q == REG_CH_EN) ? en_q :
      (ptr_q == REG_PAIR_MODE) ? pair_q :
      (ptr_q == REG_CONFIG) ? cfg_q : 8'h00;
   // Reading the upper byte of a result consumes its freshness flag.
   wire rd_clr = rd_load & rd_is_data & ~data_off[0];

   // The port only drives data; the clock is never held low.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ist_q <= I_IDLE;
         bit_cnt_q <= 4'd0;
         sr_q <= 8'h00;
         ptr_q <= 8'h00;
         ack_slot_q <= 1'b0;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end
      else if (undervoltage_lockout_s | stop_cond)
      begin
         ist_q <= I_IDLE;
         ack_slot_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end
      else if (start_cond)
      begin
         ist_q <= I_ADDR;
         bit_cnt_q <= 4'd0;
         ack_slot_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end
      else
      begin
         if (scl_rise & active)
         begin
            if (bit_cnt_q < 4'd8)
            begin
               sr_q <= {sr_q[6:0], sda_s};
               bit_cnt_q <= bit_cnt_q + 4'd1;
            end
            else
               nack_q <= sda_s;
         end
         if (byte_done)
         begin
            ack_slot_q <= 1'b1;
            sda_oe_q <= do_ack;
            if (ist_q == I_ADDR)
            begin
               rw_q <= sr_q[0];
               if (!addr_hit)
                  ist_q <= I_IDLE;
            end
            if (ist_q == I_PTR)
               ptr_q <= sr_q;
            if (ist_q == I_WDATA)
               ptr_q <= ptr_q + 8'd1;
         end
         else if (ack_end)
         begin
            ack_slot_q <= 1'b0;
            bit_cnt_q <= 4'd0;
            sda_oe_q <= rd_load & ~rd_data[7];
            if (rd_load)
               ptr_q <= ptr_q + 8'd1;
            case (ist_q)
               I_ADDR: ist_q <= rw_q ? I_RDATA : I_PTR;
               I_PTR: ist_q <= I_WDATA;
               I_RDATA: ist_q <= nack_q ? I_IDLE : I_RDATA;
               default: ist_q <= ist_q;
            endcase
         end
         else if (scl_fall & read_busy & ~ack_slot_q)
            sda_oe_q <= ~tx_q[3'd7 - bit_cnt_q[2:0]];
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tx_q <= 8'h00;
         sda_o_q <= 1'b0;
      end
      else
      begin
         if (rd_load)
            tx_q <= rd_data;
         sda_o_q <= 1'b0;
      end
   end

   // Control registers; lockout holds them at their reset value.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         en_q <= REG_RESET;
         pair_q <= REG_RESET;
         cfg_q <= REG_RESET;
      end
      else if (undervoltage_lockout_s)
      begin
         en_q <= REG_RESET;
         pair_q <= REG_RESET;
         cfg_q <= REG_RESET;
      end
      else if (reg_wr)
      begin
         if (ptr_q == REG_CH_EN)
            en_q <= sr_q;
         if (ptr_q == REG_PAIR_MODE)
            pair_q <= sr_q;
         if (ptr_q == REG_CONFIG)
            cfg_q <= sr_q;
      end
   end

   // Pair mode bits: even bit is differential, odd bit is remote diode.
   function automatic logic [2:0] chan_kind(input logic [3:0] ch,
      input logic [7:0] en, input logic [7:0] pair, input logic [7:0] cfg);
      logic [1:0] pm;
      pm = {pair[{ch[2:1], 1'b1}], pair[{ch[2:1], 1'b0}]};
      chan_kind = KIND_OFF;
      if (ch == CH_TINT)
         chan_kind = cfg[CFG_TINT_EN_BIT] ? KIND_TINT : KIND_OFF;
      else if (ch == CH_VCC)
         chan_kind = cfg[CFG_VCC_EN_BIT] ? KIND_VCC : KIND_OFF;
      else if ((ch < CH_TINT) && en[ch[2:0]])
      begin
         if (pm[1])
            chan_kind = ch[0] ? KIND_DIODE_V : KIND_REMOTE;
         else if (pm[0])
            chan_kind = ch[0] ? KIND_OFF : KIND_DIFF;
         else
            chan_kind = KIND_SINGLE;
      end
   endfunction

   seq_state_e seq_st_q;
   logic [3:0] seq_ch_q;
   logic [1:0] step_q;
   logic [2:0] kind_q;
   logic [CONV_CNT_W-1:0] conv_cnt_q;
   logic done_seen_q;
   logic [RESULT_W-1:0] result_q;

   wire [2:0] cur_kind = chan_kind(seq_ch_q, en_q, pair_q, cfg_q);
   wire conv_ok = conv_cnt_q >= CONV_CNT_W'(CONV_CYCLES - 1);
   wire wr_stb = (seq_st_q == S_STORE) & ~read_busy;
   wire more_steps = (kind_q == KIND_REMOTE) & (step_q != REMOTE_LAST_STEP);

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         seq_st_q <= S_IDLE;
         seq_ch_q <= 4'd0;
         step_q <= 2'd0;
         kind_q <= KIND_OFF;
         conv_cnt_q <= '0;
         done_seen_q <= 1'b0;
         result_q <= '0;
      end
      else if (undervoltage_lockout_s)
      begin
         seq_st_q <= S_IDLE;
         seq_ch_q <= 4'd0;
      end
      else
      begin
         case (seq_st_q)
            S_IDLE:
               if (trig_pulse)
               begin
                  seq_ch_q <= 4'd0;
                  seq_st_q <= S_PICK;
               end
            S_PICK:
               if (seq_ch_q == CH_END)
               begin
                  seq_ch_q <= 4'd0;
                  seq_st_q <= cfg_q[CFG_REPEAT_BIT] ? S_PICK : S_IDLE;
               end
               else if (cur_kind != KIND_OFF)
               begin
                  kind_q <= cur_kind;
                  step_q <= 2'd0;
                  seq_st_q <= S_START;
               end
               else
                  seq_ch_q <= seq_ch_q + 4'd1;
            S_START:
            begin
               conv_cnt_q <= '0;
               done_seen_q <= 1'b0;
               seq_st_q <= S_WAIT;
            end
            S_WAIT:
            begin
               if (!conv_ok)
                  conv_cnt_q <= conv_cnt_q + CONV_CNT_W'(1);
               if (adc_done_i)
               begin
                  done_seen_q <= 1'b1;
                  result_q <= adc_result_i;
               end
               if (done_seen_q & conv_ok)
               begin
                  if (more_steps)
                  begin
                     step_q <= step_q + 2'd1;
                     seq_st_q <= S_START;
                  end
                  else
                     seq_st_q <= S_STORE;
               end
            end
            S_STORE:
               if (!read_busy)
               begin
                  seq_ch_q <= seq_ch_q + 4'd1;
                  seq_st_q <= S_PICK;
               end
            default: seq_st_q <= S_IDLE;
         endcase
      end
   end

   // Temperatures carry 13 bits, voltages a sign and 14 bits.
   wire is_temp = (kind_q == KIND_REMOTE) | (kind_q == KIND_TINT);
   wire [7:0] st_hi = is_temp ? {1'b1, 2'b00, result_q[12:8]} :
                      {1'b1, result_q[14], result_q[13:8]};
   wire [7:0] st_lo = result_q[7:0];

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++)
      begin : g_data
         // Set wins over a clear landing in the same cycle.
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               hi_q[c] <= REG_RESET;
               lo_q[c] <= REG_RESET;
            end
            else if (undervoltage_lockout_s)
            begin
               hi_q[c] <= REG_RESET;
               lo_q[c] <= REG_RESET;
            end
            else if (wr_stb & (seq_ch_q == 4'(c)))
            begin
               hi_q[c] <= st_hi;
               lo_q[c] <= st_lo;
            end
            else if (rd_clr & (rd_ch == 4'(c)))
               hi_q[c][VALID_BIT] <= 1'b0;
         end
         assign valid_vec[c] = hi_q[c][VALID_BIT];
      end
   endgenerate

   logic adc_start_q;
   logic [2:0] adc_kind_q;
   logic [3:0] adc_chan_q;
   logic [1:0] adc_step_q;
   logic adc_kelvin_q;
   logic [NUM_PAIRS-1:0] isrc_en_q;
   wire converting = (seq_st_q == S_START) | (seq_st_q == S_WAIT);

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         adc_start_q <= 1'b0;
         adc_kind_q <= KIND_OFF;
         adc_chan_q <= 4'd0;
         adc_step_q <= 2'd0;
         adc_kelvin_q <= 1'b0;
         seq_busy_q <= 1'b0;
      end
      else
      begin
         adc_start_q <= (seq_st_q == S_START) & ~undervoltage_lockout_s;
         adc_kind_q <= kind_q;
         adc_chan_q <= seq_ch_q;
         adc_step_q <= step_q;
         adc_kelvin_q <= cfg_q[CFG_KELVIN_BIT];
         seq_busy_q <= (seq_st_q != S_IDLE);
      end
   end

   genvar p;
   generate
      for (p = 0; p < NUM_PAIRS; p++)
      begin : g_isrc
         always_ff @(posedge clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
               isrc_en_q[p] <= 1'b0;
            else
               isrc_en_q[p] <= converting & ~undervoltage_lockout_s & (kind_q == KIND_REMOTE)
                               & (seq_ch_q[2:1] == 2'(p));
         end
      end
   endgenerate

   assign sda_o = sda_o_q;
   assign sda_oe_o = sda_oe_q;
   assign adc_start_o = adc_start_q;
   assign adc_kind_o = adc_kind_q;
   assign adc_chan_o = adc_chan_q;
   assign adc_step_o = adc_step_q;
   assign adc_kelvin_o = adc_kelvin_q;
   assign isrc_en_o = isrc_en_q;
   assign seq_busy_o = seq_busy_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   skip_order_a: assert property ((seq_st_q == S_PICK) && (seq_ch_q != CH_END)
      && (cur_kind == KIND_OFF) && !undervoltage_lockout_s |=> seq_ch_q == $past(seq_ch_q) + 4'd1)
      else $error("disabled channel not skipped in order");
   start_kind_a: assert property (adc_start_o |-> adc_kind_o != KIND_OFF)
      else $error("conversion started with no kind");
   store_data_a: assert property (wr_stb && !undervoltage_lockout_s |=>
      lo_q[$past(seq_ch_q)] == $past(result_q[7:0]))
      else $error("result not stored in its register");
   valid_set_a: assert property (wr_stb && !undervoltage_lockout_s |=> valid_vec[$past(seq_ch_q)])
      else $error("freshness flag not set on new data");
   addr_miss_a: assert property (byte_done && (ist_q == I_ADDR) && !addr_hit
      && !undervoltage_lockout_s && !stop_cond && !start_cond |=> !sda_oe_o && ist_q == I_IDLE)
      else $error("foreign address acknowledged");
   undervoltage_lockout_quiet_a: assert property (undervoltage_lockout_s |=> !sda_oe_o && ist_q == I_IDLE)
      else $error("serial port active under lockout");
   undervoltage_lockout_clear_a: assert property (undervoltage_lockout_s |=> en_q == 8'h00 && cfg_q == 8'h00
      && pair_q == 8'h00 && valid_vec == '0)
      else $error("registers not cleared under lockout");
   trig_start_a: assert property (trig_pulse && (seq_st_q == S_IDLE) && !undervoltage_lockout_s
      |=> seq_st_q == S_PICK ##1 seq_busy_o)
      else $error("trigger did not start acquisition");
   // A read may still consume the flag, so only the data bits are held.
   read_freeze_a: assert property (read_busy && (seq_st_q == S_STORE)
      && !undervoltage_lockout_s |=> $stable(hi_q[seq_ch_q][6:0]) && $stable(lo_q[seq_ch_q]))
      else $error("result stored during serial read");
   isrc_on_a: assert property (adc_start_o && (adc_kind_o == KIND_REMOTE)
      |-> isrc_en_o[adc_chan_o[2:1]])
      else $error("current source off during remote conversion");
   remote_steps_a: assert property ((seq_st_q == S_STORE)
      && (kind_q == KIND_REMOTE) |-> step_q == REMOTE_LAST_STEP)
      else $error("remote result stored before all current steps");
   conv_time_a: assert property ((seq_st_q == S_WAIT) && !conv_ok
      && !undervoltage_lockout_s |=> seq_st_q == S_WAIT)
      else $error("conversion ended before minimum time");

   remote_store_c: cover property (wr_stb && (kind_q == KIND_REMOTE));
   read_clear_c: cover property (rd_clr ##[1:1000] rd_load);
   repeat_wrap_c: cover property ((seq_st_q == S_PICK) && (seq_ch_q == CH_END)
      && cfg_q[CFG_REPEAT_BIT]);
   freeze_c: cover property ((seq_st_q == S_STORE) && read_busy);

endmodule
`default_nettype wire

//--- core/mon_pkg.sv
package mon_pkg;

   // Clock and conversion timing.
   localparam int CLK_PERIOD_NS = 8;
   localparam int CONV_TIME_NS = 1_500_000;
   localparam int CONV_CYCLES_DEFAULT =
      (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_CNT_W = 18;

   // Serial pins idle high, so their synchronisers reset to that level
   // and no false edge follows reset.
   localparam logic [5:0] PIN_IDLE = 6'h03;

   // Slave address: fixed upper four bits, pins give the low three.
   localparam logic [3:0] ADDR_PREFIX = 4'h9;

   // Channel numbering in acquisition order.
   localparam int NUM_CH = 10;
   localparam int NUM_PAIRS = 4;
   localparam logic [3:0] CH_TINT = 4'h8;
   localparam logic [3:0] CH_VCC = 4'h9;
   localparam logic [3:0] CH_END = 4'hA;

   // Remote diode readings use several source current steps.
   localparam logic [1:0] REMOTE_LAST_STEP = 2'h2;

   // Register offsets.
   localparam logic [7:0] REG_STATUS_LO = 8'h00;
   localparam logic [7:0] REG_STATUS_HI = 8'h01;
   localparam logic [7:0] REG_CH_EN = 8'h02;
   localparam logic [7:0] REG_TRIGGER = 8'h03;
   localparam logic [7:0] REG_PAIR_MODE = 8'h06;
   localparam logic [7:0] REG_CONFIG = 8'h08;
   localparam logic [7:0] REG_DATA_BASE = 8'h0A;
   localparam logic [7:0] REG_DATA_LAST = 8'h1D;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Configuration bit positions.
   localparam int CFG_REPEAT_BIT = 0;
   localparam int CFG_KELVIN_BIT = 1;
   localparam int CFG_TINT_EN_BIT = 2;
   localparam int CFG_VCC_EN_BIT = 3;

   // Result layout.
   localparam int RESULT_W = 15;
   localparam int VALID_BIT = 7;

   // Conversion kinds driven to the converter.
   localparam logic [2:0] KIND_OFF = 3'h0;
   localparam logic [2:0] KIND_SINGLE = 3'h1;
   localparam logic [2:0] KIND_DIFF = 3'h2;
   localparam logic [2:0] KIND_REMOTE = 3'h3;
   localparam logic [2:0] KIND_DIODE_V = 3'h4;
   localparam logic [2:0] KIND_TINT = 3'h5;
   localparam logic [2:0] KIND_VCC = 3'h6;

   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_PTR, I_WDATA, I_RDATA} i2c_state_e;
   typedef enum logic [2:0] {S_IDLE, S_PICK, S_START, S_WAIT, S_STORE} seq_state_e;

endpackage

//--- test/i2c_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Bus master for the serial port. SCL stands high between frames and the
// master only ever pulls SDA low, so a released line reads as the pull-up.
module i2c_host_model #(
   parameter realtime HALF_NS = 62.5
) (
   // Serial bus
   output logic scl_o,
   output logic sda_pull_o,
   input wire logic sda_i
);
   initial
   begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end

   // Serves as a repeated start too when SCL is low on entry.
   task automatic start_cond();
      #(HALF_NS / 2) sda_pull_o = 1'b0;
      #(HALF_NS / 2) scl_o = 1'b1;
      #(HALF_NS) sda_pull_o = 1'b1;
      #(HALF_NS) scl_o = 1'b0;
   endtask

   task automatic stop_cond();
      #(HALF_NS / 2) sda_pull_o = 1'b1;
      #(HALF_NS / 2) scl_o = 1'b1;
      #(HALF_NS) sda_pull_o = 1'b0;
      #(HALF_NS);
   endtask

   // Data changes mid-low, so the slave's late output still meets the rise.
   task automatic xfer_byte(input logic [7:0] d, input logic mack,
                            output logic [7:0] q, output logic ack);
      logic [8:0] sh;
      sh = {d, mack};
      for (int i = 8; i >= 0; i--)
      begin
         #(HALF_NS / 2) sda_pull_o = ~sh[i];
         #(HALF_NS / 2) scl_o = 1'b1;
         #(HALF_NS) sh[i] = sda_i;
         scl_o = 1'b0;
      end
      q = sh[8:1];
      ack = sh[0];
   endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import mon_pkg::*;
   localparam int CONV = 20;
   logic clk_i, rst_n_i, scl, pull, undervoltage_lockout, rep_on;
   logic adc_done = 1'b0;
   logic sda_oe, adc_start, kelvin, busy;
   logic [2:0] pins, kind;
   logic [3:0] chan, isrc;
   logic [3:0] done_cnt = 4'h0;
   logic [1:0] step;
   logic [14:0] adc_res = 15'h0000;
   logic [14:0] last_r [0:15];
   logic [8:0] exp_q [$];
   logic [31:0] seed = 32'h61ee;
   logic [6:0] dev;
   int fail_count, cmp_count;
   int start_cnt = 0;
   wire sda_w;
   assign sda_w = ~(pull | sda_oe);

   mon_acq_ctrl #(.CONV_CYCLES(CONV)) dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w),
      .sda_o(), .sda_oe_o(sda_oe), .addr_select_bit0_i(pins[0]),
      .addr_select_bit1_i(pins[1]), .addr_select_bit2_i(pins[2]),
      .undervoltage_lockout_i(undervoltage_lockout), .adc_start_o(adc_start),
      .adc_kind_o(kind), .adc_chan_o(chan), .adc_step_o(step),
      .adc_kelvin_o(kelvin), .adc_done_i(adc_done), .adc_result_i(adc_res),
      .isrc_en_o(isrc), .seq_busy_o(busy));
   i2c_host_model host (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda_w));

   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [15:0] fmt(input logic [2:0] k,
                                       input logic [14:0] r);
      if (k == KIND_TINT || k == KIND_REMOTE)
         return {3'b100, r[12:0]};
      return {1'b1, r};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic send(input logic [7:0] d);
      logic [7:0] q;
      logic a;
      host.xfer_byte(d, 1'b1, q, a);
      chk({15'h0, a}, 16'h0000);
   endtask

   task automatic wr(input logic [7:0] ptr, input logic [7:0] v);
      host.start_cond();
      send({dev, 1'b0});
      send(ptr);
      send(v);
      host.stop_cond();
   endtask

   // Upper byte first, so its freshness flag is read before it clears.
   task automatic rd_chk(input logic [7:0] ptr, input logic [15:0] e);
      logic [15:0] v;
      logic a;
      host.start_cond();
      send({dev, 1'b0});
      send(ptr);
      host.start_cond();
      send({dev, 1'b1});
      host.xfer_byte(8'hFF, 1'b0, v[15:8], a);
      host.xfer_byte(8'hFF, 1'b1, v[7:0], a);
      host.stop_cond();
      chk(v, e);
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while ((exp_q.size() != 0 || busy !== 1'b0) && n < 5000)
      begin
         @(posedge clk_i);
         n++;
      end
      chk({15'h0, n >= 5000}, 16'h0000);
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Converter stand-in: each start is checked against the oldest note, else a channel 0 differential start when rep_on is set.
   always @(posedge clk_i)
   begin
      adc_done <= (done_cnt == 4'h1);
      if (done_cnt != 4'h0)
         done_cnt <= done_cnt - 4'h1;
      if (adc_done === 1'b1)
      begin
         chk({12'h0, isrc}, (kind == KIND_REMOTE) ?
             16'h1 << chan[3:1] : 16'h0000);
         last_r[chan] <= adc_res;
      end
      if (adc_start === 1'b1)
      begin
         chk({7'h0, kind, chan, step}, (exp_q.size() != 0) ?
             {7'h0, exp_q.pop_front()} : rep_on ?
             {7'h0, KIND_DIFF, 4'h0, 2'h0} : 16'hFFFF);
         start_cnt <= start_cnt + 1;
         seed = lfsr(seed);
         adc_res <= seed[14:0];
         done_cnt <= 4'h5;
      end
   end

   // Roughly 160 us of bus traffic is expected; this allows nearly four times that.
   initial
   begin
      #600_000;
      fail_count++;
      close_out();
   end

   initial
   begin
      logic [7:0] q;
      logic a;
      int n0;
      rst_n_i = 1'b0;
      undervoltage_lockout = 1'b0;
      rep_on = 1'b0;
      pins = 3'h0;
      fail_count = 0;
      cmp_count = 0;
      dev = {ADDR_PREFIX, 3'h0};
      repeat (4) @(posedge clk_i);
      chk({9'h0, sda_oe, adc_start, isrc, busy}, 16'h0000);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      for (int p = 0; p < 8; p++)
      begin
         @(posedge clk_i);
         pins <= p[2:0];
         dev <= {ADDR_PREFIX, p[2:0]};
         repeat (4) @(posedge clk_i);
         host.start_cond();
         host.xfer_byte({ADDR_PREFIX, p[2:0] ^ 3'h5, 1'b0}, 1'b1, q, a);
         chk({15'h0, a}, 16'h0001);
         host.start_cond();
         send({dev, 1'b0});
         host.stop_cond();
      end
      $display("test address done");
      rd_chk(REG_STATUS_LO, 16'h0000);
      rd_chk(REG_PAIR_MODE, 16'h0000);
      rd_chk(REG_CONFIG, 16'h0000);
      $display("test defaults done");
      wr(REG_CH_EN, 8'h85);
      wr(REG_CONFIG, 8'h06);
      chk({15'h0, kelvin}, 16'h0001);
      exp_q.push_back({KIND_SINGLE, 4'h0, 2'h0});
      exp_q.push_back({KIND_SINGLE, 4'h2, 2'h0});
      exp_q.push_back({KIND_SINGLE, 4'h7, 2'h0});
      exp_q.push_back({KIND_TINT, CH_TINT, 2'h0});
      wr(REG_TRIGGER, 8'h01);
      wait_idle();
      rd_chk(REG_DATA_BASE, fmt(KIND_SINGLE, last_r[0]));
      rd_chk(REG_DATA_BASE, {1'b0, last_r[0]});
      rd_chk(REG_DATA_BASE + 8'h02, 16'h0000);
      rd_chk(REG_DATA_BASE + 8'h0E, fmt(KIND_SINGLE, last_r[7]));
      rd_chk(REG_DATA_BASE + 8'h10, fmt(KIND_TINT, last_r[8]));
      $display("test sequence done");
      wr(REG_PAIR_MODE, 8'h09);
      wr(REG_CH_EN, 8'h0F);
      wr(REG_CONFIG, 8'h08);
      chk({15'h0, kelvin}, 16'h0000);
      exp_q.push_back({KIND_DIFF, 4'h0, 2'h0});
      for (int s = 0; s < 3; s++)
         exp_q.push_back({KIND_REMOTE, 4'h2, s[1:0]});
      exp_q.push_back({KIND_DIODE_V, 4'h3, 2'h0});
      exp_q.push_back({KIND_VCC, CH_VCC, 2'h0});
      wr(REG_TRIGGER, 8'h01);
      wait_idle();
      rd_chk(REG_DATA_BASE, fmt(KIND_DIFF, last_r[0]));
      rd_chk(REG_DATA_BASE + 8'h04, fmt(KIND_REMOTE, last_r[2]));
      rd_chk(REG_DATA_BASE + 8'h06, fmt(KIND_DIODE_V, last_r[3]));
      rd_chk(REG_DATA_BASE + 8'h12, fmt(KIND_VCC, last_r[9]));
      $display("test pair modes done");
      rep_on = 1'b1;
      n0 = start_cnt;
      wr(REG_CH_EN, 8'h01);
      wr(REG_CONFIG, 8'h01);
      wr(REG_TRIGGER, 8'h01);
      wr(REG_CONFIG, 8'h00);
      wait_idle();
      rep_on = 1'b0;
      chk({15'h0, start_cnt > n0 + 1}, 16'h0001);
      rd_chk(REG_DATA_BASE, fmt(KIND_DIFF, last_r[0]));
      $display("test repeat done");
      @(posedge clk_i);
      undervoltage_lockout <= 1'b1;
      repeat (5) @(posedge clk_i);
      host.start_cond();
      host.xfer_byte({dev, 1'b0}, 1'b1, q, a);
      chk({15'h0, a}, 16'h0001);
      host.stop_cond();
      @(posedge clk_i);
      undervoltage_lockout <= 1'b0;
      repeat (5) @(posedge clk_i);
      rd_chk(REG_PAIR_MODE, 16'h0000);
      rd_chk(REG_DATA_BASE + 8'h04, 16'h0000);
      $display("test lockout done");
      close_out();
   end
endmodule
`default_nettype wire
